// ---- timer_pkg.sv ----
package timer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WIDE_W  = 10;
  localparam int unsigned HIGH_W  = 2;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned NUM_CMP = 4;

  // ----------------------------------------------------------------
  // Register select codes on the byte bus
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_HIGH_LATCH = 3'h0;
  localparam logic [2:0] ADDR_COUNTER    = 3'h1;
  localparam logic [2:0] ADDR_CMP_A      = 3'h2;
  localparam logic [2:0] ADDR_CMP_B      = 3'h3;
  localparam logic [2:0] ADDR_CMP_C      = 3'h4;
  localparam logic [2:0] ADDR_CMP_D      = 3'h5;
  localparam logic [2:0] ADDR_CTRL_A     = 3'h6;

  // ----------------------------------------------------------------
  // Control register A fields and reset value
  // ----------------------------------------------------------------
  localparam int unsigned MODE_A_HI_BIT = 7;
  localparam int unsigned MODE_A_LO_BIT = 6;
  localparam int unsigned MODE_B_HI_BIT = 5;
  localparam int unsigned MODE_B_LO_BIT = 4;
  localparam int unsigned FORCE_A_BIT   = 3;
  localparam int unsigned FORCE_B_BIT   = 2;
  localparam int unsigned PWM_A_BIT     = 1;
  localparam int unsigned PWM_B_BIT     = 0;
  localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_A_RMASK  = 8'hF3;

  // ----------------------------------------------------------------
  // Output mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_OFF    = 2'h0;
  localparam logic [1:0] CODE_TOGGLE = 2'h1;
  localparam logic [1:0] CODE_CLEAR  = 2'h2;
  localparam logic [1:0] CODE_SET    = 2'h3;

  localparam logic [9:0] WIDE_RESET   = 10'h000;
  localparam logic [9:0] WIDE_BOTTOM  = 10'h000;
  localparam logic [1:0] HIGH_RESET   = 2'h0;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

endpackage

// ---- out_mode_if.sv ----
`timescale 1ns/10ps
interface out_mode_if;
  logic [1:0] mode_code;
  logic       pwm_en;
  logic       wgm_lo;
  logic       six_mode;
  logic       force_strobe;
  logic [1:0] force_code;
  logic       match_evt;
  logic       bottom_evt;
  logic       count_down;
  logic       wave;
  logic       true_oe_n;
  logic       comp_oe_n;
  logic       pair_oe_n;

  modport ctrl (
    output mode_code, pwm_en, wgm_lo, six_mode, force_strobe, force_code,
           match_evt, bottom_evt, count_down,
    input  wave, true_oe_n, comp_oe_n, pair_oe_n
  );
  modport unit (
    input  mode_code, pwm_en, wgm_lo, six_mode, force_strobe, force_code,
           match_evt, bottom_evt, count_down,
    output wave, true_oe_n, comp_oe_n, pair_oe_n
  );
endinterface

// ---- out_mode_unit.sv ----
`timescale 1ns/10ps
module out_mode_unit (
  input  wire logic core_clk,
  input  wire logic rst_n,
  out_mode_if.unit  om
);

  logic       any_on;

  // Stored channel A mode is not off
  assign any_on = (om.mode_code != timer_pkg::CODE_OFF);

  // Waveform output update
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      om.wave <= 1'b0;
    end else if (om.force_strobe) begin
      // Force takes the written code, even when PWM was on before
      case (om.force_code)
        timer_pkg::CODE_TOGGLE: om.wave <= ~om.wave;
        timer_pkg::CODE_CLEAR:  om.wave <= 1'b0;
        timer_pkg::CODE_SET:    om.wave <= 1'b1;
        default:                om.wave <= om.wave;
      endcase
    end else if (!om.pwm_en) begin
      if (om.match_evt) begin
        case (om.mode_code)
          timer_pkg::CODE_TOGGLE: om.wave <= ~om.wave;
          timer_pkg::CODE_CLEAR:  om.wave <= 1'b0;
          timer_pkg::CODE_SET:    om.wave <= 1'b1;
          default:                om.wave <= om.wave;
        endcase
      end
    end else if (om.wgm_lo) begin
      // Dual slope: up-match and down-match act oppositely
      if (om.match_evt && any_on) begin
        om.wave <= (om.mode_code == timer_pkg::CODE_SET) ^ om.count_down;
      end
    end else if (any_on) begin
      // Single slope: match wins over bottom
      if (om.match_evt) begin
        om.wave <= (om.mode_code == timer_pkg::CODE_SET);
      end else if (om.bottom_evt) begin
        om.wave <= (om.mode_code != timer_pkg::CODE_SET);
      end
    end
  end

  // Pin drive enables, low while the pin is driven
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      om.true_oe_n <= 1'b1;
      om.comp_oe_n <= 1'b1;
      om.pair_oe_n <= 1'b1;
    end else begin
      om.true_oe_n <= !any_on;
      om.comp_oe_n <= !(om.pwm_en && any_on &&
                        (om.six_mode || om.mode_code == timer_pkg::CODE_TOGGLE));
      om.pair_oe_n <= !(om.pwm_en && om.six_mode && any_on);
    end
  end

endmodule

// ---- wide_timer_access_and_out_mode.sv ----
`timescale 1ns/10ps
// Overview of operation
// - CPU reaches 10-bit registers byte-wise
// - One shared 2-bit high-byte latch
// - Low-byte write commits latch plus byte
// - Low-byte read copies upper bits to latch
// - Control A layout, reset zero, strobes write-only
// - Nonzero channel A mode takes the true pin
// - Complement pin for code 01 in PWM, or any nonzero code in six-output PWM
// - Mode meaning follows PWM enable and wave bits
// - Non-PWM codes toggle, clear or set on match
// - Fast PWM clear/set on match and bottom
// - Dual-slope PWM acts by counting direction
// - Single-slope six-output drives every pair
// - Dual-slope six-output drives every pair
// - Force strobe written with PWM bit clear applies action now, reads zero
// - PWM enable selects PWM on compare A
// - Low wave bit selects dual-slope output action; counting direction comes from count_down
module wide_timer_access_and_out_mode (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       wave_gen_mode_lo,
  input  wire logic       wave_gen_mode_hi,
  input  wire logic       six_output_mode,
  input  wire logic       count_tick,
  input  wire logic       count_down,
  output logic      [9:0] wide_counter_value,
  output logic      [9:0] compare_value_a,
  output logic            waveform_a,
  output logic            compare_pin_a_oe_n,
  output logic            compare_pin_a_n_oe_n,
  output logic            paired_compare_pins_oe_n
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Registers and their next values
  logic [1:0] shared_high_byte_latch_reg;
  logic [9:0] counter_reg;
  logic [9:0] counter_next;
  logic [9:0] cmp_reg [timer_pkg::NUM_CMP];
  logic [7:0] ctrl_a_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Decode strobes and counter events
  logic       cpu_is_wide;
  logic [9:0] wide_sel;
  logic       match_now;
  logic       bottom_now;
  logic       ctrl_wr;
  logic       latch_wr;
  logic       counter_wr;
  logic       wide_rd;

  out_mode_if om ();

  // ----------------------------------------------------------------
  // Byte access decode
  // ----------------------------------------------------------------

  // Selected 10-bit register for the low-byte path
  always_comb begin
    cpu_is_wide = 1'b1;
    wide_sel    = timer_pkg::WIDE_RESET;
    case (cpu_addr)
      timer_pkg::ADDR_COUNTER: wide_sel = counter_reg;
      timer_pkg::ADDR_CMP_A:   wide_sel = cmp_reg[0];
      timer_pkg::ADDR_CMP_B:   wide_sel = cmp_reg[1];
      timer_pkg::ADDR_CMP_C:   wide_sel = cmp_reg[2];
      timer_pkg::ADDR_CMP_D:   wide_sel = cmp_reg[3];
      default:                 cpu_is_wide = 1'b0;
    endcase
  end

  // Write strobes by target
  assign ctrl_wr    = cpu_wr && (cpu_addr == timer_pkg::ADDR_CTRL_A);
  assign latch_wr   = cpu_wr && (cpu_addr == timer_pkg::ADDR_HIGH_LATCH);
  assign counter_wr = cpu_wr && (cpu_addr == timer_pkg::ADDR_COUNTER);

  // Low-byte read of a 10-bit register copies its upper bits
  assign wide_rd    = cpu_rd && cpu_is_wide;

  // ----------------------------------------------------------------
  // Shared high-byte latch
  // ----------------------------------------------------------------

  // Written directly, or loaded from a low-byte read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_high_byte_latch_reg <= timer_pkg::HIGH_RESET;
    end else if (latch_wr) begin
      shared_high_byte_latch_reg <= cpu_wdata[1:0];
    end else if (wide_rd) begin
      shared_high_byte_latch_reg <= wide_sel[9:8];
    end
  end

  // ----------------------------------------------------------------
  // Counter value
  // ----------------------------------------------------------------

  // CPU low-byte write beats a tick from the counting engine
  always_comb begin
    counter_next = counter_reg;
    if (counter_wr) begin
      counter_next = {shared_high_byte_latch_reg, cpu_wdata};
    end else if (count_tick) begin
      counter_next = count_down ? counter_reg - 10'h001 : counter_reg + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_reg <= timer_pkg::WIDE_RESET;
    end else begin
      counter_reg <= counter_next;
    end
  end

  // ----------------------------------------------------------------
  // Compare registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < timer_pkg::NUM_CMP; gi++) begin : g_cmp
      // Low-byte write commits the latch with it
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_reg[gi] <= timer_pkg::WIDE_RESET;
        end else if (cpu_wr && cpu_addr == timer_pkg::ADDR_CMP_A + 3'(gi)) begin
          cmp_reg[gi] <= {shared_high_byte_latch_reg, cpu_wdata};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control register A
  // ----------------------------------------------------------------

  // Force strobes are never stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= timer_pkg::CTRL_A_RESET;
    end else if (ctrl_wr) begin
      ctrl_a_reg <= cpu_wdata & timer_pkg::CTRL_A_RMASK;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Read data is returned one cycle after the read strobe
  always_comb begin
    rdata_next = timer_pkg::BYTE_ZERO;
    if (cpu_is_wide) begin
      rdata_next = wide_sel[7:0];
    end else if (cpu_addr == timer_pkg::ADDR_HIGH_LATCH) begin
      rdata_next = {6'h00, shared_high_byte_latch_reg};
    end else if (cpu_addr == timer_pkg::ADDR_CTRL_A) begin
      rdata_next = ctrl_a_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= timer_pkg::BYTE_ZERO;
    end else if (cpu_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Channel A output mode
  // ----------------------------------------------------------------

  // Events seen on the counter as it steps
  assign match_now  = count_tick && (counter_reg == cmp_reg[0]);
  assign bottom_now = count_tick && (counter_reg == timer_pkg::WIDE_BOTTOM);

  // Mode selection inputs to the waveform unit
  assign om.mode_code    = ctrl_a_reg[timer_pkg::MODE_A_HI_BIT:timer_pkg::MODE_A_LO_BIT];
  assign om.pwm_en       = ctrl_a_reg[timer_pkg::PWM_A_BIT];
  assign om.wgm_lo       = wave_gen_mode_lo;
  assign om.six_mode     = six_output_mode && wave_gen_mode_hi;
  assign om.match_evt    = match_now;
  assign om.bottom_evt   = bottom_now;
  assign om.count_down   = count_down;

  // Force strobe uses the code and PWM bit of the same write
  assign om.force_strobe = ctrl_wr && cpu_wdata[timer_pkg::FORCE_A_BIT] &&
                           !cpu_wdata[timer_pkg::PWM_A_BIT];
  assign om.force_code   = cpu_wdata[timer_pkg::MODE_A_HI_BIT:timer_pkg::MODE_A_LO_BIT];

  out_mode_unit u_out_mode (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .om       (om)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Register views and waveform, straight from flops
  assign cpu_rdata                = rdata_reg;
  assign wide_counter_value       = counter_reg;
  assign compare_value_a          = cmp_reg[0];
  assign waveform_a               = om.wave;

  // Active-low pin drive enables, straight from the unit's flops
  assign compare_pin_a_oe_n       = om.true_oe_n;
  assign compare_pin_a_n_oe_n     = om.comp_oe_n;
  assign paired_compare_pins_oe_n = om.pair_oe_n;

endmodule

// ---- wide_timer_access_and_out_mode_assertions.sv ----
`timescale 1ns/10ps
module wide_timer_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       wave_gen_mode_lo,
  input wire logic       six_output_mode,
  input wire logic       count_tick,
  input wire logic       count_down,
  input wire logic [9:0] wide_counter_value,
  input wire logic [9:0] compare_value_a,
  input wire logic       waveform_a,
  input wire logic       compare_pin_a_oe_n,
  input wire logic       compare_pin_a_n_oe_n
);
  logic [7:0] ctrl_seen;
  // Shadow of the last control write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ctrl_seen <= 8'h00;
    else if (cpu_wr && cpu_addr == 3'h6) ctrl_seen <= cpu_wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Byte access path
  // ----------------------------------------------------------------
  chk_force_reads_zero:
    assert property (cpu_rd && cpu_addr == 3'h6 |=> cpu_rdata[3:2] == 2'h0) else $error("force bits read set");
  chk_unmapped_reads_zero:
    assert property (cpu_rd && cpu_addr == 3'h7 |=> cpu_rdata == 8'h00) else $error("unmapped read nonzero");
  chk_counter_low_commit:
    assert property (cpu_wr && cpu_addr == 3'h1 |=> wide_counter_value[7:0] == $past(cpu_wdata))
    else $error("counter low byte not committed");
  chk_compare_low_commit:
    assert property (cpu_wr && cpu_addr == 3'h2 |=> compare_value_a[7:0] == $past(cpu_wdata))
    else $error("compare low byte not committed");
  chk_latch_write_idle:
    assert property (cpu_wr && cpu_addr == 3'h0 && !count_tick
      |=> $stable(wide_counter_value) && $stable(compare_value_a)) else $error("latch write changed value");
  chk_low_read_copy:
    assert property (cpu_rd && cpu_addr == 3'h1 ##1 !cpu_wr ##1 cpu_rd && cpu_addr == 3'h0
      |=> cpu_rdata == 8'($past(wide_counter_value, 3) >> 8)) else $error("latch copy wrong");
  // ----------------------------------------------------------------
  // Output mode
  // ----------------------------------------------------------------
  chk_true_pin_follows:
    assert property (cpu_wr && cpu_addr == 3'h6 ##1 !(cpu_wr && cpu_addr == 3'h6)
      |=> compare_pin_a_oe_n == (ctrl_seen[7:6] == 2'h0)) else $error("true pin enable wrong");
  chk_comp_pin_follows:
    assert property (cpu_wr && cpu_addr == 3'h6 && !six_output_mode
      ##1 !(cpu_wr && cpu_addr == 3'h6) && !six_output_mode
      |=> compare_pin_a_n_oe_n == !(ctrl_seen[1] && ctrl_seen[7:6] == 2'h1)) else $error("comp pin wrong");
  chk_force_action:
    assert property (cpu_wr && cpu_addr == 3'h6 && cpu_wdata[3] && !cpu_wdata[1] && cpu_wdata[7]
      && !count_tick |=> waveform_a == ctrl_seen[6]) else $error("force action wrong");
  chk_fast_bottom_set:
    assert property (count_tick && !cpu_wr && ctrl_seen[1] && ctrl_seen[7:6] != 2'h0 && !wave_gen_mode_lo
      && wide_counter_value == 10'h000 && compare_value_a != 10'h000
      |=> waveform_a == (ctrl_seen[7:6] != 2'h3)) else $error("bottom action wrong");
  chk_fast_match_wins:
    assert property (count_tick && !cpu_wr && ctrl_seen[1] && ctrl_seen[7:6] != 2'h0 && !wave_gen_mode_lo
      && wide_counter_value == compare_value_a |=> waveform_a == (ctrl_seen[7:6] == 2'h3))
    else $error("fast match action wrong");
  chk_dual_match_dir:
    assert property (count_tick && !cpu_wr && ctrl_seen[1] && ctrl_seen[7:6] != 2'h0 && wave_gen_mode_lo
      && wide_counter_value == compare_value_a
      |=> waveform_a == ($past(count_down) ^ (ctrl_seen[7:6] == 2'h3))) else $error("dual match wrong");
  // Main scenarios reached
  cover property (count_tick && ctrl_seen[1] && wave_gen_mode_lo);
  cover property (cpu_wr && cpu_addr == 3'h6 && cpu_wdata[3]);
  cover property (!compare_pin_a_n_oe_n);
endmodule
bind wide_timer_access_and_out_mode wide_timer_checker u_chk (.*);

// ---- cpu_byte_model.sv ----
`timescale 1ns/10ps
module cpu_byte_model (
  input  wire logic       core_clk,
  output logic      [2:0] cpu_addr,
  output logic            cpu_wr,
  output logic            cpu_rd,
  output logic      [7:0] cpu_wdata,
  input  wire logic [7:0] cpu_rdata
);
  // Idle bus at time zero
  initial begin
    cpu_addr = 3'h7;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end
  // One byte write; lines scrambled once released
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge core_clk);
    cpu_wr = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
    @(negedge core_clk);
  endtask
  // One byte read, data taken after the answering edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge core_clk);
    d = cpu_rdata;
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    @(negedge core_clk);
  endtask
  // Ten-bit write, latch first, never interleaved with another access
  task automatic wr10(input logic [2:0] a, input logic [9:0] v);
    wr(3'h0, {6'h00, v[9:8]});
    wr(a, v[7:0]);
  endtask
endmodule

// ---- wide_timer_access_and_out_mode_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module wide_timer_access_and_out_mode_tb;
  logic       core_clk, rst_n, cpu_wr, cpu_rd, count_tick, count_down, waveform_a, w, six, dn;
  logic       wave_gen_mode_lo, wave_gen_mode_hi, six_output_mode;
  logic       compare_pin_a_oe_n, compare_pin_a_n_oe_n, paired_compare_pins_oe_n;
  logic [2:0] cpu_addr, a;
  logic [7:0] cpu_wdata, cpu_rdata, d, c;
  logic [9:0] wide_counter_value, compare_value_a, v, cnt, cm;
  integer     errors = 0, compares = 0, seed = 69, i, k;

  cpu_byte_model u_cpu (.core_clk(core_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
  wide_timer_access_and_out_mode u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .wave_gen_mode_lo(wave_gen_mode_lo),
    .wave_gen_mode_hi(wave_gen_mode_hi), .six_output_mode(six_output_mode),
    .count_tick(count_tick), .count_down(count_down), .wide_counter_value(wide_counter_value),
    .compare_value_a(compare_value_a), .waveform_a(waveform_a),
    .compare_pin_a_oe_n(compare_pin_a_oe_n), .compare_pin_a_n_oe_n(compare_pin_a_n_oe_n),
    .paired_compare_pins_oe_n(paired_compare_pins_oe_n));

  // Next waveform level after one event
  function automatic logic nxt(input logic q, input logic [1:0] code, input logic pwm, lo, dd, mt, bt);
    if (code == 2'h0) return q;
    if (!pwm) return mt ? (code == 2'h1 ? ~q : code == 2'h3) : q;
    if (lo) return mt ? dd ^ (code == 2'h3) : q;
    return mt ? code == 2'h3 : (bt ? code != 2'h3 : q);
  endfunction
  // Verdict and end of run
  task tally_and_finish;
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    errors++;
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, count_tick, count_down, wave_gen_mode_lo, wave_gen_mode_hi, six_output_mode, w} = 7'h00;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    `CHK({waveform_a, compare_pin_a_oe_n, compare_pin_a_n_oe_n, paired_compare_pins_oe_n}, 4'h7)
    u_cpu.rd(3'h6, d);
    `CHK(d, 8'h00)
    for (i = 0; i < 20; i++) begin
      v = (i == 0) ? 10'h1FF : 10'($random(seed));
      a = 3'h1 + 3'(i % 5);
      u_cpu.wr10(a, v);
      if (a == 3'h1) `CHK(wide_counter_value, v)
      if (a == 3'h2) `CHK(compare_value_a, v)
      u_cpu.wr(3'h0, {6'h00, ~v[9:8]});
      u_cpu.rd(a, d);
      `CHK(d, v[7:0])
      u_cpu.rd(3'h0, d);
      `CHK(d, {6'h00, v[9:8]})
    end
    u_cpu.wr10(3'h1, 10'h2A5);
    u_cpu.wr(3'h2, 8'h3C);
    `CHK(compare_value_a, 10'h23C)
    u_cpu.wr(3'h7, 8'hFF);
    u_cpu.rd(3'h7, d);
    `CHK(d, 8'h00)
    u_cpu.wr(3'h6, 8'hFF);
    u_cpu.rd(3'h6, d);
    `CHK(d, 8'hF3)
    `CHK(waveform_a, w)
    for (i = 0; i < 4; i++) begin
      c = {2'(8'h5B >> (2 * i)), 6'h08};
      u_cpu.wr(3'h6, c);
      w = nxt(w, c[7:6], 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      `CHK(waveform_a, w)
    end
    for (i = 0; i < 40; i++) begin
      c = 8'($random(seed));
      c[3] = 1'b0;
      wave_gen_mode_lo = 1'($random(seed));
      six = c[1] & 1'($random(seed));
      six_output_mode = six;
      wave_gen_mode_hi = six | 1'($random(seed));
      u_cpu.wr(3'h6, c);
      cm = 10'($random(seed)) & 10'h007;
      cnt = 10'($random(seed)) & 10'h007;
      u_cpu.wr10(3'h2, cm);
      u_cpu.wr10(3'h1, cnt);
      for (k = 0; k < 8; k++) begin
        dn = wave_gen_mode_lo & (cnt != 10'h000) & 1'($random(seed));
        count_down = dn;
        count_tick = 1'b1;
        w = nxt(w, c[7:6], c[1], wave_gen_mode_lo, dn, cnt == cm, cnt == 10'h000);
        cnt = dn ? cnt - 10'h001 : cnt + 10'h001;
        @(negedge core_clk);
        `CHK(waveform_a, w)
        `CHK(wide_counter_value, cnt)
      end
      count_tick = 1'b0;
      `CHK(compare_pin_a_oe_n, c[7:6] == 2'h0)
      `CHK(compare_pin_a_n_oe_n, !(c[1] && c[7:6] != 2'h0 && (c[7:6] == 2'h1 || six)))
      `CHK(paired_compare_pins_oe_n, !(six && c[7:6] != 2'h0))
    end
    tally_and_finish;
  end
endmodule
